// [hw/fsp_cfg.svh]
// Register offsets, field positions, reset values and timing constants
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH
// Register offsets (word index on the plain port)
`define FSP_FORMAT_OFS 3'h0
`define FSP_CONTROL_OFS 3'h1
`define FSP_STATUS_OFS 3'h2
`define FSP_FIFOCTL_OFS 3'h3
`define FSP_COUNT_OFS 3'h4
`define FSP_TXPORT_OFS 3'h5
`define FSP_RXPORT_OFS 3'h6
`define FSP_MASK_OFS 3'h7
// Format register fields
`define FSP_CHR_BIT 6
`define FSP_PE_BIT 5
`define FSP_ODD_BIT 4
`define FSP_STOP_BIT 3
// Control register fields
`define FSP_CKS_HI_BIT 1
`define FSP_CKS_LO_BIT 0
`define FSP_DIV_LSB 8
// FIFO control fields
`define FSP_RTRG_LSB 6
`define FSP_TTRG_LSB 4
`define FSP_MCE_BIT 3
`define FSP_TFRST_BIT 2
`define FSP_RFRST_BIT 1
`define FSP_LOOP_BIT 0
// Status bits
`define FSP_ST_FER 0
`define FSP_ST_PER 1
`define FSP_ST_BRK 2
`define FSP_ST_RDF 3
`define FSP_ST_DR 4
`define FSP_ST_TX_EMPTY_FLAG 5
`define FSP_ST_ORUN 6
// Reset values
`define FSP_DIV_RST 8'h00
// Oversampling ratio
`define FSP_OVERSAMPLE 16
`endif

// [hw/fsp_pkg.sv]
// Types shared by the serial port design
`default_nettype none
package fsp_pkg;
  // Serial frame format as software programs it
  typedef struct packed {
    logic seven_bit;
    logic parity_on;
    logic parity_odd;
    logic two_stop;
  } fsp_format_t;
  // Frame engine states
  typedef enum logic [2:0] {
    FSP_IDLE = 3'b000,
    FSP_START = 3'b001,
    FSP_DATA = 3'b010,
    FSP_PAR = 3'b011,
    FSP_STOP = 3'b100
  } fsp_state_t;
endpackage
`default_nettype wire

// [hw/fsp_top.sv]
// Asynchronous serial port with 16-entry transmit and receive FIFOs
// How it works
// [RL1] Two 16-byte FIFOs, transmit and receive
// [RL2] Receiver resynchronises on every start bit
// [RL3] Format bit 6 picks 7 or 8 bits
// [RL4] Format bit 5 adds parity bit
// [RL5] Format bit 3 picks one or two stops
// [RL6] Flag framing, parity and break on receive
// [RL7] Receive full at threshold, data ready otherwise; data ready here is set whenever the FIFO is not empty
// [RL8] Transmit empty flag when buffer drains
// [RL9] Both FIFO counts readable any time
// [RL10] RTS out, CTS in gates transmit
// [RL11] Select 00: internal clock, pin unused
// [RL12] Select 01: drive 16x clock out
// [RL13] Select 1x: external 16x clock input
// [RL14] External clock must be 16x bit rate
// [RL15] Receive threshold 1/4/8/14, resets to 1
// [RL16] Transmit threshold 8/4/2/1, resets to 8
// [RL17] Modem control off: CTS active, RTS 0
// [RL18] Loop-back routes transmit into receive
// [RL19] Start low, LSB first, stop high, centre
`include "fsp_cfg.svh"
`default_nettype none
module fsp_top
  import fsp_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [2:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Serial link
  input wire logic rxd_in,
  output logic txd_out,
  input wire logic cts_n_in,
  output logic rts_n_out,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  // Interrupt
  output logic irq_out
);
  ////////////////////////////////////////////////////////////////////////
  // Registers
  fsp_format_t fmt; // Frame format
  logic [7:0] ctrl_div; // Baud divisor
  logic [1:0] cks; // Clock select
  logic [7:0] fctl; // FIFO control
  logic [6:0] status; // Sticky status
  logic [6:0] mask; // Interrupt mask
  logic [AW:0] tx_cnt; // Transmit fill
  logic [AW:0] rx_cnt; // Receive fill
  logic [7:0] tx_mem [DEPTH]; // Transmit storage
  logic [10:0] rx_mem [DEPTH]; // Receive data plus error bits
  logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  // Synchronisers for pins
  logic [1:0] rxd_s, cts_s, sck_s;
  logic sck_d; // Delayed sync'd external clock for edges
  // Thresholds decoded from control fields
  function automatic logic [AW:0] rx_thr(input logic [1:0] s);
    case (s)
      2'h0: rx_thr = 5'h01;
      2'h1: rx_thr = 5'h04;
      2'h2: rx_thr = 5'h08;
      default: rx_thr = 5'h0E;
    endcase
  endfunction
  function automatic logic [AW:0] tx_thr(input logic [1:0] s);
    case (s)
      2'h0: tx_thr = 5'h08;
      2'h1: tx_thr = 5'h04;
      2'h2: tx_thr = 5'h02;
      default: tx_thr = 5'h01;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage feeds only the second
  always_ff @(posedge clk_in) begin
    rxd_s <= {rxd_s[0], rxd_in};
    cts_s <= {cts_s[0], cts_n_in};
    sck_s <= {sck_s[0], sck_in};
    sck_d <= sck_s[1];
  end

  ////////////////////////////////////////////////////////////////////////
  // 16x tick: internal divider or external pin edge
  logic [7:0] baud_cnt;
  logic tick;
  logic ext_clk;
  assign ext_clk = cks[1]; // see [RL13]
  // External clock is assumed exactly 16x the bit rate, see [RL14]
  assign tick = ext_clk ? (sck_s[1] & ~sck_d) : (baud_cnt == 8'h00);
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || ext_clk || baud_cnt == 8'h00) begin
      baud_cnt <= ctrl_div; // see [RL11]
    end else begin
      baud_cnt <= baud_cnt - 8'h01;
    end
  end
  // Clock out at 16x the bit rate: high in the upper half of the divider
  // count, so the pin period equals the tick period; enable only in 01.
  // Limitation: with divisor 0 a tick comes every clock, which one flop
  // cannot draw, so the pin then stays low
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sck_out <= 1'b0;
      sck_oe_out <= 1'b0;
    end else begin
      sck_oe_out <= (cks == 2'b01); // see [RL12]
      sck_out <= baud_cnt > (ctrl_div >> 1); // see [RL12]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  logic tx_push, rx_pop;
  assign tx_push = wr_in && addr_in == `FSP_TXPORT_OFS
                   && tx_cnt != 5'(DEPTH);
  assign rx_pop = rd_in && addr_in == `FSP_RXPORT_OFS && rx_cnt != 5'h00;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fmt <= '0;
      ctrl_div <= `FSP_DIV_RST;
      cks <= 2'h0;
      fctl <= 8'h00; // see [RL15] [RL16] [RL17]
      mask <= 7'h00;
    end else if (wr_in) begin
      case (addr_in)
        `FSP_FORMAT_OFS: fmt <= {wdata_in[`FSP_CHR_BIT],
          wdata_in[`FSP_PE_BIT], wdata_in[`FSP_ODD_BIT],
          wdata_in[`FSP_STOP_BIT]};
        `FSP_CONTROL_OFS: begin
          cks <= wdata_in[`FSP_CKS_HI_BIT:`FSP_CKS_LO_BIT];
          ctrl_div <= wdata_in[`FSP_DIV_LSB+:8];
        end
        `FSP_FIFOCTL_OFS: fctl <= wdata_in[7:0];
        `FSP_MASK_OFS: mask <= wdata_in[6:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Modem control and loop-back
  logic cts_ok, rx_line;
  assign cts_ok = !fctl[`FSP_MCE_BIT] || !cts_s[1]; // see [RL17] [RL10]
  assign rx_line = fctl[`FSP_LOOP_BIT] ? txd_out : rxd_s[1]; // see [RL18]
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rts_n_out <= 1'b0;
    end else begin
      // Ready to accept while receive FIFO has room, see [RL10] [RL17]
      rts_n_out <= fctl[`FSP_MCE_BIT] && rx_cnt == 5'(DEPTH);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter
  fsp_state_t tx_st;
  logic [3:0] tx_sub; // Ticks within a bit
  logic [2:0] tx_bit; // Data bit index
  logic [7:0] tx_sh;
  logic tx_par, tx_stop2;
  logic tx_pop;
  assign tx_pop = tx_st == FSP_IDLE && tx_cnt != 5'h00 && cts_ok;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_st <= FSP_IDLE;
      txd_out <= 1'b1; // Line idles high
      tx_sub <= 4'h0;
      tx_bit <= 3'h0;
      tx_sh <= 8'h00;
      tx_par <= 1'b0;
      tx_stop2 <= 1'b0;
    end else begin
      case (tx_st)
        FSP_IDLE: begin
          // Transmission waits for CTS before a new frame, see [RL10]
          if (tx_pop) begin
            tx_sh <= tx_mem[tx_rp];
            tx_par <= fmt.parity_odd;
            tx_st <= FSP_START;
            tx_sub <= 4'h0;
            txd_out <= 1'b0; // see [RL19]
          end
        end
        FSP_START: if (tick) begin
          tx_sub <= tx_sub + 4'h1;
          if (tx_sub == 4'hF) begin
            tx_st <= FSP_DATA;
            tx_bit <= 3'h0;
            txd_out <= tx_sh[0]; // LSB first, see [RL19]
            tx_par <= tx_par ^ tx_sh[0];
            tx_sh <= tx_sh >> 1;
          end
        end
        FSP_DATA: if (tick) begin
          tx_sub <= tx_sub + 4'h1;
          if (tx_sub == 4'hF) begin
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == (fmt.seven_bit ? 3'h6 : 3'h7)) begin // see [RL3]
              tx_stop2 <= fmt.two_stop;
              tx_st <= fmt.parity_on ? FSP_PAR : FSP_STOP; // see [RL4]
              txd_out <= fmt.parity_on ? tx_par : 1'b1;
            end else begin
              txd_out <= tx_sh[0];
              tx_par <= tx_par ^ tx_sh[0];
              tx_sh <= tx_sh >> 1;
            end
          end
        end
        FSP_PAR: if (tick) begin
          tx_sub <= tx_sub + 4'h1;
          if (tx_sub == 4'hF) begin
            tx_st <= FSP_STOP;
            txd_out <= 1'b1;
          end
        end
        FSP_STOP: if (tick) begin
          tx_sub <= tx_sub + 4'h1;
          if (tx_sub == 4'hF) begin
            tx_stop2 <= 1'b0; // Second stop bit if chosen, see [RL5]
            if (!tx_stop2) begin
              tx_st <= FSP_IDLE;
            end
          end
        end
        default: tx_st <= FSP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver: hunts each start bit afresh, see [RL2]
  fsp_state_t rx_st;
  logic [3:0] rx_sub;
  logic [2:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_par, rx_push, rx_allzero;
  logic rx_prev; // Line level at the last tick, for start edges
  logic [10:0] rx_word; // {brk, per, fer, data}
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_st <= FSP_IDLE;
      rx_sub <= 4'h0;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
      rx_par <= 1'b0;
      rx_push <= 1'b0;
      rx_allzero <= 1'b0;
      rx_word <= 11'h000;
      rx_prev <= 1'b1; // Idle level, so reset leaves no false edge
    end else begin
      rx_push <= 1'b0;
      if (tick) begin
        rx_prev <= rx_line;
      end
      case (rx_st)
        // A start is a falling edge: the low tail of a bad stop bit or a
        // break must not be taken for the next start bit, see [RL19]
        FSP_IDLE: if (tick && rx_prev && !rx_line) begin
          rx_st <= FSP_START;
          rx_sub <= 4'h1;
        end
        FSP_START: if (tick) begin
          rx_sub <= rx_sub + 4'h1;
          // Centre of start bit: reject glitches, see [RL19]
          if (rx_sub == 4'h7) begin
            if (rx_line) begin
              rx_st <= FSP_IDLE;
            end else begin
              rx_st <= FSP_DATA;
              rx_sub <= 4'h0;
              rx_bit <= 3'h0;
              rx_sh <= 8'h00;
              rx_par <= fmt.parity_odd;
              rx_allzero <= 1'b1;
            end
          end
        end
        FSP_DATA: if (tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == 4'hF) begin
            rx_bit <= rx_bit + 3'h1;
            rx_par <= rx_par ^ rx_line;
            rx_allzero <= rx_allzero & ~rx_line;
            rx_sh[rx_bit] <= rx_line; // see [RL3]
            if (rx_bit == (fmt.seven_bit ? 3'h6 : 3'h7)) begin
              rx_st <= fmt.parity_on ? FSP_PAR : FSP_STOP; // see [RL4]
            end
          end
        end
        FSP_PAR: if (tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == 4'hF) begin
            rx_par <= rx_par ^ rx_line;
            rx_allzero <= rx_allzero & ~rx_line;
            rx_st <= FSP_STOP;
          end
        end
        FSP_STOP: if (tick) begin
          rx_sub <= rx_sub + 4'h1;
          // Only the first stop bit is checked on receive
          if (rx_sub == 4'hF) begin
            rx_st <= FSP_IDLE;
            rx_push <= 1'b1;
            // Break: whole frame low including stop, see [RL6]
            rx_word <= {rx_allzero & ~rx_line,
                        fmt.parity_on & rx_par, ~rx_line, rx_sh};
          end
        end
        default: rx_st <= FSP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // FIFO storage and counts, see [RL1] [RL9]
  logic rx_wr_ok;
  assign rx_wr_ok = rx_push && rx_cnt != 5'(DEPTH);
  always_ff @(posedge clk_in) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= wdata_in[7:0];
    end
    if (rx_wr_ok) begin
      rx_mem[rx_wp] <= rx_word;
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || fctl[`FSP_TFRST_BIT]) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else begin
      tx_wp <= tx_wp + AW'(tx_push);
      tx_rp <= tx_rp + AW'(tx_pop);
      tx_cnt <= tx_cnt + 5'(tx_push) - 5'(tx_pop);
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || fctl[`FSP_RFRST_BIT]) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else begin
      rx_wp <= rx_wp + AW'(rx_wr_ok);
      rx_rp <= rx_rp + AW'(rx_pop);
      rx_cnt <= rx_cnt + 5'(rx_wr_ok) - 5'(rx_pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky status: set wins over write-one-to-clear
  logic [6:0] ev;
  logic [10:0] rx_head;
  assign rx_head = rx_mem[rx_rp];
  always_comb begin
    ev = 7'h00;
    ev[`FSP_ST_FER] = rx_wr_ok && rx_word[8]; // see [RL6]
    ev[`FSP_ST_PER] = rx_wr_ok && rx_word[9];
    ev[`FSP_ST_BRK] = rx_wr_ok && rx_word[10];
    ev[`FSP_ST_RDF] = rx_cnt >= rx_thr(fctl[`FSP_RTRG_LSB+:2]); // [RL15]
    ev[`FSP_ST_DR] = rx_cnt != 5'h00; // see [RL7]
    ev[`FSP_ST_TX_EMPTY_FLAG] = tx_cnt < tx_thr(fctl[`FSP_TTRG_LSB+:2]); // [RL16]
    ev[`FSP_ST_ORUN] = rx_push && !rx_wr_ok;
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      status <= 7'h00;
    end else if (wr_in && addr_in == `FSP_STATUS_OFS) begin
      status <= (status & ~wdata_in[6:0]) | ev; // see [RL7] [RL8]
    end else begin
      status <= status | ev;
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_out <= 16'h0000;
    end else if (rd_in) begin
      case (addr_in)
        `FSP_FORMAT_OFS: rdata_out <= {9'h000, fmt.seven_bit,
          fmt.parity_on, fmt.parity_odd, fmt.two_stop, 3'h0};
        `FSP_CONTROL_OFS: rdata_out <= {ctrl_div, 6'h00, cks};
        `FSP_STATUS_OFS: rdata_out <= {9'h000, status};
        `FSP_FIFOCTL_OFS: rdata_out <= {8'h00, fctl};
        `FSP_COUNT_OFS: rdata_out <= {3'h0, tx_cnt, 3'h0, rx_cnt}; // [RL9]
        // Empty FIFO reads zero, never a stale or unwritten entry
        `FSP_RXPORT_OFS: rdata_out <= (rx_cnt != 5'h00) ?
          {5'h00, rx_head} : 16'h0000;
        `FSP_MASK_OFS: rdata_out <= {9'h000, mask};
        default: rdata_out <= 16'h0000;
      endcase
    end else begin
      rdata_out <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_RX_THRESH: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    rx_cnt >= rx_thr(fctl[7:6]) |=> status[`FSP_ST_RDF]) // see [RL15]
    else $error("receive full flag missed");
  AST_TX_EMPTY: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tx_cnt < tx_thr(fctl[5:4]) |=> status[`FSP_ST_TX_EMPTY_FLAG]) // see [RL16]
    else $error("transmit empty flag missed");
  AST_RTS_OFF: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !fctl[`FSP_MCE_BIT] |=> !rts_n_out) // see [RL17]
    else $error("rts not held low");
  AST_CNT_MAX: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tx_cnt <= 5'(DEPTH) && rx_cnt <= 5'(DEPTH)) // see [RL1]
    else $error("fifo count overflow");
  AST_START_LOW: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tx_pop |=> !txd_out) // see [RL19]
    else $error("start bit not low");
  AST_IDLE_HIGH: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tx_st == FSP_IDLE && $past(tx_st) == FSP_IDLE |-> txd_out) // see [RL19]
    else $error("idle line not high");
  AST_CTS_GATE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    fctl[`FSP_MCE_BIT] && cts_s[1] && tx_st == FSP_IDLE
    |=> tx_st == FSP_IDLE) // see [RL10]
    else $error("frame started without cts");
  AST_SCK_OE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cks != 2'b01 |=> !sck_oe_out) // see [RL11]
    else $error("clock pin driven when unused");
  AST_LOOP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    fctl[`FSP_LOOP_BIT] |-> rx_line == txd_out) // see [RL18]
    else $error("loop-back path broken");
endmodule
`default_nettype wire

// [tb/fsp_remote.sv]
// Remote serial device model facing the port's serial pins
`default_nettype none
module fsp_remote (
  // Clock
  input wire logic clk_in,
  // Serial link
  input wire logic txd_in,
  output logic rxd_out,
  output logic cts_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_clks = 16; // Clocks per bit, set by the bench
  int nbits = 8; // Data plus parity bits expected
  int stops = 1; // Stop bits checked
  int stop_errs = 0; // Stop bits seen low
  logic cts_hold = 1'b1; // Not clear to send until told
  logic [9:0] capq[$]; // Captured frames, oldest first
  logic [9:0] cap; // Frame being captured
  initial rxd_out = 1'b1; // Line idles high
  assign cts_n_out = cts_hold; // Flow control toward the port
  ////////////////////////////////////////
  // Own timing from each start edge, counted on the shared system clock
  always begin
    @(negedge txd_in);
    cap = '0;
    repeat (bit_clks / 2) @(posedge clk_in);
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_clks) @(posedge clk_in);
      cap[i] = txd_in; // Centre sample, LSB first
    end
    for (int s = 0; s < stops; s++) begin
      repeat (bit_clks) @(posedge clk_in);
      if (txd_in !== 1'b1) begin
        stop_errs++; // Stop bits must be high
      end
    end
    capq.push_back(cap);
  end
  ////////////////////////////////////////
  // Drive a prepared frame, then one idle bit so the next start is seen
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_out <= f[i]; // Bit order as built by the bench
      repeat (bit_clks) @(posedge clk_in);
    end
    rxd_out <= 1'b1;
    repeat (bit_clks) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// [tb/fsp_top_tb.sv]
// Self-checking bench for the serial port
`include "fsp_cfg.svh"
`default_nettype none
module fsp_top_tb import fsp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench-side drivers
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic sck_in = 1'b0;
  logic sck_run = 1'b0; // External 16x clock only while selected
  // Design outputs and link
  logic [15:0] rdata;
  logic txd, rxd, cts_n, rts_n, sck_out, sck_oe, irq;
  int err_count = 0;
  int checks_done = 0;
  // One row: format, byte sent both ways, expected receive port word
  typedef struct packed {
    fsp_format_t fmt;
    logic [7:0] d;
    logic [15:0] exp_rx;
  } fsp_row_t;
  localparam fsp_row_t ROWS [8] = '{
    '{4'h0, 8'hA5, 16'h00A5}, '{4'h1, 8'h3C, 16'h003C},
    '{4'h4, 8'h81, 16'h0081}, '{4'h7, 8'h7E, 16'h007E},
    '{4'h8, 8'hC5, 16'h0045}, '{4'h9, 8'h2B, 16'h002B},
    '{4'hE, 8'hF0, 16'h0070}, '{4'hD, 8'h55, 16'h0055}};
  ////////////////////////////////////////
  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;
  // External 16x clock, four system clocks a tick
  always #10 sck_in <= sck_run ? ~sck_in : 1'b0;
  fsp_top fsp_top_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
    .rxd_in(rxd), .txd_out(txd), .cts_n_in(cts_n), .rts_n_out(rts_n),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe_out(sck_oe),
    .irq_out(irq));
  fsp_remote fsp_remote_i (
    .clk_in(clk_in), .txd_in(txd), .rxd_out(rxd), .cts_n_out(cts_n));
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] got,
                       input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bus write; a gap cycle keeps the strobe from being set twice at once
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
    @(posedge clk_in);
  endtask
  // Bus read; data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    @(posedge clk_in);
    d = rdata;
  endtask
  // Frame as it goes on the line: start, data LSB first, parity, stops
  function automatic logic [11:0] frame(input fsp_format_t fmt,
                                        input logic [7:0] d, output int n);
    int nd;
    logic [11:0] f;
    nd = fmt.seven_bit ? 7 : 8;
    f = 12'hFFF;
    f[0] = 1'b0;
    for (int i = 0; i < nd; i++) f[1 + i] = d[i];
    n = 1 + nd;
    if (fmt.parity_on) begin
      f[n] = (^(d & (fmt.seven_bit ? 8'h7F : 8'hFF))) ^ fmt.parity_odd;
      n++;
    end
    n = n + (fmt.two_stop ? 2 : 1);
    return f;
  endfunction
  // Bounded wait for frames at the far side
  task automatic wait_caps(input int n);
    for (int i = 0; i < 8000 && fsp_remote_i.capq.size() < n; i++)
      @(posedge clk_in);
    check("frames seen", 16'(fsp_remote_i.capq.size()), 16'(n));
  endtask
  // Compare the oldest captured frame with the expected bits
  task automatic cap_cmp(input fsp_format_t fmt, input logic [7:0] d);
    logic [11:0] f;
    logic [15:0] e, g;
    int n;
    f = frame(fmt, d, n);
    e = {6'h00, f[10:1]} & 16'((1 << fsp_remote_i.nbits) - 1);
    g = {6'h00, fsp_remote_i.capq.pop_front()};
    check("tx frame", g, e);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog, several times the expected run
  initial begin
    repeat (60000) @(posedge clk_in);
    err_count++;
    print_verdict();
  end
  ////////////////////////////////////////
  initial begin
    logic [15:0] v;
    logic [11:0] f;
    int n;
    int k;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    check("reset pins", {12'h0, txd, rts_n, sck_oe, irq}, 16'h8);
    rd(`FSP_STATUS_OFS, v);
    check("reset status", v, 16'h0020);
    rd(`FSP_COUNT_OFS, v);
    check("reset counts", v, 16'h0000);
    rd(`FSP_RXPORT_OFS, v);
    check("empty read", v, 16'h0000);
    $display("done: reset");
    // Eight formats covering each width, parity and stop setting, both ways, CTS not clear while modem control is off
    foreach (ROWS[r]) begin
      wr(`FSP_FORMAT_OFS, {9'h000, ROWS[r].fmt, 3'h0});
      fsp_remote_i.nbits = (ROWS[r].fmt.seven_bit ? 7 : 8) +
                           ROWS[r].fmt.parity_on;
      fsp_remote_i.stops = ROWS[r].fmt.two_stop ? 2 : 1;
      wr(`FSP_TXPORT_OFS, {8'h00, ROWS[r].d});
      wr(`FSP_TXPORT_OFS, {8'h00, ~ROWS[r].d});
      f = frame(ROWS[r].fmt, ROWS[r].d, n);
      fsp_remote_i.send(f, n);
      wait_caps(2);
      cap_cmp(ROWS[r].fmt, ROWS[r].d);
      cap_cmp(ROWS[r].fmt, ~ROWS[r].d);
      repeat (4) @(posedge clk_in);
      rd(`FSP_RXPORT_OFS, v);
      check("rx data", v, ROWS[r].exp_rx);
    end
    check("stop bits", 16'(fsp_remote_i.stop_errs), 16'h0000);
    $display("done: formats");
    // Clock output, then external clock
    wr(`FSP_CONTROL_OFS, 16'h0101); // Divisor 1: tick every other clock
    repeat (2) @(posedge clk_in);
    k = 0;
    for (int i = 0; i < 32; i++) begin
      v[0] = sck_out;
      @(posedge clk_in);
      if (sck_out !== v[0]) k++;
    end
    check("sck toggles", 16'(k), 16'h0020);
    check("sck drive", {15'h0000, sck_oe}, 16'h0001);
    wr(`FSP_FORMAT_OFS, 16'h0000);
    wr(`FSP_CONTROL_OFS, 16'h0003); // Low select bit has no say here
    sck_run <= 1'b1;
    fsp_remote_i.bit_clks = 64;
    fsp_remote_i.nbits = 8;
    fsp_remote_i.stops = 1;
    wr(`FSP_TXPORT_OFS, 16'h005A);
    wait_caps(1);
    cap_cmp(4'h0, 8'h5A);
    check("sck input", {15'h0000, sck_oe}, 16'h0000);
    sck_run <= 1'b0;
    fsp_remote_i.bit_clks = 16;
    wr(`FSP_CONTROL_OFS, 16'h0000);
    check("sck idle", {15'h0000, sck_oe}, 16'h0000);
    $display("done: clock select");
    // Parity, framing and break on receive
    wr(`FSP_FORMAT_OFS, 16'h0020);
    wr(`FSP_STATUS_OFS, 16'h007F);
    f = frame(4'h4, 8'h96, n);
    f[9] = ~f[9];
    fsp_remote_i.send(f, n);
    f[9] = ~f[9];
    f[10] = 1'b0;
    fsp_remote_i.send(f, n);
    fsp_remote_i.send(12'h000, 11);
    repeat (4) @(posedge clk_in);
    rd(`FSP_RXPORT_OFS, v);
    check("parity err", v, 16'h0296);
    rd(`FSP_RXPORT_OFS, v);
    check("framing err", v, 16'h0196);
    rd(`FSP_RXPORT_OFS, v);
    check("break", v, 16'h0500);
    rd(`FSP_STATUS_OFS, v);
    check("err flags", v & 16'h0007, 16'h0007);
    $display("done: receive errors");
    // Receive threshold 4, interrupt, RTS when full
    wr(`FSP_FORMAT_OFS, 16'h0000);
    wr(`FSP_FIFOCTL_OFS, 16'h0048);
    wr(`FSP_STATUS_OFS, 16'h007F);
    for (int i = 0; i < 16; i++) begin
      f = frame(4'h0, 8'(i), n);
      fsp_remote_i.send(f, n);
      repeat (4) @(posedge clk_in);
      if (i == 2) begin
        rd(`FSP_STATUS_OFS, v);
        check("below thr", v & 16'h0008, 16'h0000);
      end
      if (i == 3) begin
        rd(`FSP_STATUS_OFS, v);
        check("at thr", v & 16'h0018, 16'h0018);
        wr(`FSP_MASK_OFS, 16'h0008);
        repeat (2) @(posedge clk_in);
        check("irq on", {15'h0000, irq}, 16'h0001);
        wr(`FSP_MASK_OFS, 16'h0000);
        repeat (2) @(posedge clk_in);
        check("irq masked", {15'h0000, irq}, 16'h0000);
      end
    end
    rd(`FSP_COUNT_OFS, v);
    check("rx count", v, 16'h0010);
    check("rts full", {15'h0000, rts_n}, 16'h0001);
    wr(`FSP_MASK_OFS, 16'h0008);
    wr(`FSP_FIFOCTL_OFS, 16'h004A);
    wr(`FSP_FIFOCTL_OFS, 16'h0048);
    wr(`FSP_STATUS_OFS, 16'h0008);
    repeat (2) @(posedge clk_in);
    check("irq cleared", {15'h0000, irq}, 16'h0000);
    check("rts free", {15'h0000, rts_n}, 16'h0000);
    rd(`FSP_COUNT_OFS, v);
    check("rx flushed", v, 16'h0000);
    wr(`FSP_MASK_OFS, 16'h0000);
    $display("done: receive threshold");
    // Fill transmit past full while CTS holds it back, then drain
    wr(`FSP_FIFOCTL_OFS, 16'h0008);
    for (int i = 0; i < 17; i++) wr(`FSP_TXPORT_OFS, {8'h00, 8'(i)});
    rd(`FSP_COUNT_OFS, v);
    check("tx full", v, 16'h1000);
    wr(`FSP_STATUS_OFS, 16'h007F);
    rd(`FSP_STATUS_OFS, v);
    check("tx above thr", v & 16'h0020, 16'h0000);
    check("cts held", 16'(fsp_remote_i.capq.size()), 16'h0000);
    fsp_remote_i.cts_hold <= 1'b0;
    wait_caps(16);
    for (int i = 0; i < 16; i++) cap_cmp(4'h0, 8'(i));
    rd(`FSP_STATUS_OFS, v);
    check("tx drained", v & 16'h0020, 16'h0020);
    rd(`FSP_COUNT_OFS, v);
    check("tx count", v, 16'h0000);
    $display("done: transmit fifo");
    // Loop-back
    wr(`FSP_FIFOCTL_OFS, 16'h0001);
    wr(`FSP_TXPORT_OFS, 16'h00C3);
    repeat (400) @(posedge clk_in);
    rd(`FSP_RXPORT_OFS, v);
    check("loop back", v, 16'h00C3);
    $display("done: loop-back");
    // Reset in mid-frame: line back to idle, control cleared, only the transmit empty flag set
    wr(`FSP_TXPORT_OFS, 16'h0033);
    repeat (40) @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    check("rst line", {15'h0000, txd}, 16'h0001);
    rd(`FSP_FIFOCTL_OFS, v);
    check("rst fifo ctl", v, 16'h0000);
    rd(`FSP_STATUS_OFS, v);
    check("rst status", v, 16'h0020);
    $display("done: mid-run reset");
    print_verdict();
  end
endmodule
`default_nettype wire
